// ===== design/pgc_axil_slave.sv
// pgc_axil_slave.sv: AXI4-Lite slave front end; one write and one read
// under way at most; hands simple strobes to the register file.
// assumes: master on sys_clk_i; register file answers combinationally.
`timescale 1ns/10ps
`default_nettype none
`include "pgc_params.svh"

module pgc_axil_slave (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire pgc_pkg::pgc_axil_req_type axil_req_i,
    output pgc_pkg::pgc_axil_rsp_type axil_rsp_o,
    output logic wr_stb_o,
    output logic [`PGC_ADDR_W-1:0] wr_addr_o,
    output logic [31:0] wr_data_o,
    output logic [3:0] wr_strb_o,
    input wire logic [1:0] wr_resp_i,
    output logic rd_stb_o,
    output logic [`PGC_ADDR_W-1:0] rd_addr_o,
    input wire logic [31:0] rd_data_i,
    input wire logic [1:0] rd_resp_i
);
    // ----------------------------------------
    // write channel state
    // ----------------------------------------
    logic aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
    logic [`PGC_ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_q, bresp_d;
    // read channel state
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    // write: address and data in either order, then the response
    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (axil_req_i.awvalid && awready_q) begin
            aw_full_d = 1'b1;
            awaddr_d = axil_req_i.awaddr;
        end
        if (axil_req_i.wvalid && wready_q) begin
            w_full_d = 1'b1;
            wdata_d = axil_req_i.wdata;
            wstrb_d = axil_req_i.wstrb;
        end
        if (wr_stb_o) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_resp_i;
        end else if (bvalid_q && axil_req_i.bready) begin
            bvalid_d = 1'b0;
        end
        awready_d = ~aw_full_d & ~bvalid_d;
        wready_d = ~w_full_d & ~bvalid_d;
    end

    // read: one cycle from address taken to data valid
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rd_stb_o) begin
            rvalid_d = 1'b1;
            rdata_d = rd_data_i;
            rresp_d = rd_resp_i;
        end else if (rvalid_q && axil_req_i.rready) begin
            rvalid_d = 1'b0;
        end
        arready_d = ~rvalid_d;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bresp_q <= `PGC_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `PGC_RESP_OKAY;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // strobes to the register file and the response channels
    assign wr_stb_o = aw_full_q & w_full_q;
    assign wr_addr_o = awaddr_q;
    assign wr_data_o = wdata_q;
    assign wr_strb_o = wstrb_q;
    assign rd_stb_o = axil_req_i.arvalid & arready_q;
    assign rd_addr_o = axil_req_i.araddr;
    assign axil_rsp_o = '{awready: awready_q, wready: wready_q, bresp: bresp_q,
                          bvalid: bvalid_q, arready: arready_q, rdata: rdata_q,
                          rresp: rresp_q, rvalid: rvalid_q};

endmodule

`default_nettype wire

// ===== design/pgc_gate_cell.sv
// pgc_gate_cell.sv: gate for one peripheral: clock enable and register
// access qualifier, delayed from the gate bit by a fixed number of clocks.
// assumes: all inputs on sys_clk_i; the clock gate cell sits outside.
`timescale 1ns/10ps
`default_nettype none

module pgc_gate_cell #(
    parameter int DELAY = 1
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic off_i,
    input wire logic present_i,
    input wire logic run_req_i,
    input wire logic reg_wr_i,
    output logic clk_en_o,
    output logic reg_en_o,
    output logic reg_wr_o
);
    logic [DELAY-1:0] en_pipe_q, en_pipe_d;
    logic [DELAY-1:0] acc_pipe_q, acc_pipe_d;
    logic reg_wr_q, reg_wr_d;

    // delay lines from the gate bit to the peripheral
    always_comb begin
        en_pipe_d = en_pipe_q << 1;
        acc_pipe_d = acc_pipe_q << 1;
        en_pipe_d[0] = ~off_i & present_i & run_req_i;
        acc_pipe_d[0] = ~off_i & present_i;
        reg_wr_d = reg_wr_i & acc_pipe_q[DELAY-1];
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            en_pipe_q <= '0;
            acc_pipe_q <= '0;
            reg_wr_q <= 1'b0;
        end else begin
            en_pipe_q <= en_pipe_d;
            acc_pipe_q <= acc_pipe_d;
            reg_wr_q <= reg_wr_d;
        end
    end

    assign clk_en_o = en_pipe_q[DELAY-1];
    assign reg_en_o = acc_pipe_q[DELAY-1];
    assign reg_wr_o = reg_wr_q;

endmodule

`default_nettype wire

// ===== design/pgc_top.sv
// pgc_top.sv: peripheral clock gate control; one software gate register
// that stops the clocks and register access of ten peripherals.
// assumes: AXI4-Lite master and all peripherals on sys_clk_i; clock gate
// cells outside take periph_clk_en_o as their enable.
//
// Notes on behaviour
// [RULE_01] a set gate bit stops every clock enable of its peripheral.
// [RULE_02] while gated off a peripheral's register writes are dropped and reads flagged invalid.
// [RULE_03] a peripheral runs only when its bit is clear and it is present in this variant.
// [RULE_04] after reset every gate bit of a present peripheral reads zero.
// [RULE_05] setting a gate bit disables its peripheral one instruction cycle later.
// [RULE_06] clearing a gate bit re-enables it one instruction cycle later if it asks to run.
// [RULE_07] gate bits sit at 15,14,13,12,11,9,7,5,3,0 for timer5..timer1, pwm, i2c, uart, spi, adc.
// [RULE_08] a gate bit of one disables its peripheral and zero enables it.
// [RULE_09] bits 10, 8, 6, 4, 2 and 1 read zero and ignore writes.
// [RULE_10] without timers 4 and 5 their bits read zero, ignore writes and gate nothing.
`timescale 1ns/10ps
`default_nettype none
`include "pgc_params.svh"

module pgc_top #(
    parameter logic [15:0] PRESENT_MASK = `PGC_IMPL_MASK,
    parameter int GATE_DELAY = `PGC_GATE_DELAY_CYC
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire pgc_pkg::pgc_axil_req_type axil_req_i,
    output pgc_pkg::pgc_axil_rsp_type axil_rsp_o,
    input wire logic [`PGC_NUM_PERIPH-1:0] periph_run_req_i,
    input wire logic [`PGC_NUM_PERIPH-1:0] periph_reg_wr_i,
    output logic [`PGC_NUM_PERIPH-1:0] periph_clk_en_o,
    output logic [`PGC_NUM_PERIPH-1:0] periph_reg_en_o,
    output logic [`PGC_NUM_PERIPH-1:0] periph_reg_wr_o
);

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------

    // slot index to bit position in the gate register
    function automatic int unsigned slot_pos(input int unsigned slot);
        int unsigned pos;
        pos = `PGC_ADC_BIT;
        case (slot)
            0: pos = `PGC_ADC_BIT;
            1: pos = `PGC_SPI_BIT;
            2: pos = `PGC_UART_BIT;
            3: pos = `PGC_I2C_BIT;
            4: pos = `PGC_PWM_BIT;
            5: pos = `PGC_TIMER1_BIT;
            6: pos = `PGC_TIMER2_BIT;
            7: pos = `PGC_TIMER3_BIT;
            8: pos = `PGC_TIMER4_BIT;
            9: pos = `PGC_TIMER5_BIT;
            default: pos = `PGC_ADC_BIT;
        endcase
        return pos; // RULE_07
    endfunction

    // register select from a bus address, used by both read and write
    function automatic pgc_pkg::pgc_sel_type reg_sel(input logic [`PGC_ADDR_W-1:0] addr);
        pgc_pkg::pgc_sel_type sel;
        if (addr == `PGC_GATE_OFFSET) begin
            sel = pgc_pkg::SEL_GATE;
        end else if (addr == `PGC_STATUS_OFFSET) begin
            sel = pgc_pkg::SEL_STATUS;
        end else if (addr == `PGC_PRESENT_OFFSET) begin
            sel = pgc_pkg::SEL_PRESENT;
        end else begin
            sel = pgc_pkg::SEL_NONE;
        end
        return sel;
    endfunction

    // ----------------------------------------
    // bus front end
    // ----------------------------------------
    logic wr_stb;
    logic [`PGC_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [1:0] wr_resp;
    logic rd_stb;
    logic [`PGC_ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic [1:0] rd_resp;

    // bits that exist in this variant and can be written
    localparam logic [15:0] WRITE_MASK = PRESENT_MASK & `PGC_IMPL_MASK;

    pgc_axil_slave u_slave (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .axil_req_i(axil_req_i),
        .axil_rsp_o(axil_rsp_o),
        .wr_stb_o(wr_stb),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .wr_strb_o(wr_strb),
        .wr_resp_i(wr_resp),
        .rd_stb_o(rd_stb),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data),
        .rd_resp_i(rd_resp)
    );

    // ----------------------------------------
    // gate register
    // ----------------------------------------
    pgc_pkg::pgc_gate_reg_type gate_q, gate_d;
    logic [15:0] gate_bits_d;

    // byte-lane write into the gate register, unimplemented bits held low
    always_comb begin
        gate_bits_d = gate_q;
        if (wr_stb && reg_sel(wr_addr) == pgc_pkg::SEL_GATE) begin
            if (wr_strb[0]) begin
                gate_bits_d[7:0] = wr_data[7:0];
            end
            if (wr_strb[1]) begin
                gate_bits_d[15:8] = wr_data[15:8];
            end
        end
        gate_d = gate_bits_d & WRITE_MASK; // RULE_09 RULE_10
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            gate_q <= `PGC_GATE_RESET; // RULE_04
        end else begin
            gate_q <= gate_d;
        end
    end

    // write response: gate register accepts, read-only ones refuse
    always_comb begin
        wr_resp = `PGC_RESP_DECERR;
        if (reg_sel(wr_addr) == pgc_pkg::SEL_GATE) begin
            wr_resp = `PGC_RESP_OKAY;
        end else if (reg_sel(wr_addr) == pgc_pkg::SEL_STATUS) begin
            wr_resp = `PGC_RESP_SLVERR;
        end else if (reg_sel(wr_addr) == pgc_pkg::SEL_PRESENT) begin
            wr_resp = `PGC_RESP_SLVERR;
        end
    end

    // ----------------------------------------
    // per-peripheral gates
    // ----------------------------------------
    logic [`PGC_NUM_PERIPH-1:0] slot_off;
    logic [`PGC_NUM_PERIPH-1:0] slot_present;

    // one gate cell per peripheral, each picking its own register bit
    for (genvar s = 0; s < `PGC_NUM_PERIPH; s++) begin : g_slot
        assign slot_off[s] = gate_q[slot_pos(s)]; // RULE_08
        assign slot_present[s] = WRITE_MASK[slot_pos(s)]; // RULE_03 RULE_10

        pgc_gate_cell #(
            .DELAY(GATE_DELAY)
        ) u_cell (
            .sys_clk_i(sys_clk_i),
            .sys_rst_i(sys_rst_i),
            .off_i(slot_off[s]), // RULE_01 RULE_05
            .present_i(slot_present[s]), // RULE_03
            .run_req_i(periph_run_req_i[s]), // RULE_06
            .reg_wr_i(periph_reg_wr_i[s]),
            .clk_en_o(periph_clk_en_o[s]),
            .reg_en_o(periph_reg_en_o[s]), // RULE_02
            .reg_wr_o(periph_reg_wr_o[s]) // RULE_02
        );
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    logic [15:0] run_status;

    // running peripherals reported at their gate bit positions
    always_comb begin
        run_status = 16'h0000;
        for (int unsigned s = 0; s < `PGC_NUM_PERIPH; s++) begin
            run_status[slot_pos(s)] = periph_clk_en_o[s];
        end
    end

    // read mux, 16-bit registers in the low half of the word
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_resp = `PGC_RESP_OKAY;
        if (reg_sel(rd_addr) == pgc_pkg::SEL_GATE) begin
            rd_data = {16'h0000, gate_q};
        end else if (reg_sel(rd_addr) == pgc_pkg::SEL_STATUS) begin
            rd_data = {16'h0000, run_status};
        end else if (reg_sel(rd_addr) == pgc_pkg::SEL_PRESENT) begin
            rd_data = {16'h0000, WRITE_MASK};
        end else begin
            rd_resp = `PGC_RESP_DECERR;
        end
    end

    // read strobe only paces the slave; the mux is pure decode
    logic rd_stb_unused;
    assign rd_stb_unused = rd_stb;

endmodule

`default_nettype wire

// ===== include/pgc_params.svh
// pgc_params.svh: offsets, field positions, reset values and timing
// counts of the peripheral clock gate control block.
// assumes: included by bare name; definitions only.
`ifndef PGC_PARAMS_SVH
`define PGC_PARAMS_SVH

// bus geometry and register byte offsets
`define PGC_ADDR_W 8
`define PGC_GATE_OFFSET 8'h00
`define PGC_STATUS_OFFSET 8'h04
`define PGC_PRESENT_OFFSET 8'h08

// gate register layout
`define PGC_GATE_RESET 16'h0000
`define PGC_IMPL_MASK 16'hFAA9
`define PGC_TIMER45_MASK 16'hC000
`define PGC_TIMER5_BIT 15
`define PGC_TIMER4_BIT 14
`define PGC_TIMER3_BIT 13
`define PGC_TIMER2_BIT 12
`define PGC_TIMER1_BIT 11
`define PGC_PWM_BIT 9
`define PGC_I2C_BIT 7
`define PGC_UART_BIT 5
`define PGC_SPI_BIT 3
`define PGC_ADC_BIT 0
`define PGC_NUM_PERIPH 10

// timing: one instruction cycle, least time, rounded up to clocks
`define PGC_CLK_PERIOD_PS 10000
`define PGC_INSTR_CYCLE_PS 10000
`define PGC_GATE_DELAY_CYC \
    ((`PGC_INSTR_CYCLE_PS + `PGC_CLK_PERIOD_PS - 1) / `PGC_CLK_PERIOD_PS)

// bus responses
`define PGC_RESP_OKAY 2'h0
`define PGC_RESP_SLVERR 2'h2
`define PGC_RESP_DECERR 2'h3

`endif

// ===== include/pgc_pkg.sv
// pgc_pkg.sv: types of the peripheral clock gate control block.
// assumes: pgc_params.svh is on the include path.
`include "pgc_params.svh"

package pgc_pkg;

    // ----------------------------------------
    // register bus carriers
    // ----------------------------------------
    typedef struct packed {
        logic [`PGC_ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [`PGC_ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } pgc_axil_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } pgc_axil_rsp_type;

    // ----------------------------------------
    // gate register fields, msb first
    // ----------------------------------------
    typedef struct packed {
        logic timer5_off;
        logic timer4_off;
        logic timer3_off;
        logic timer2_off;
        logic timer1_off;
        logic unused10;
        logic pwm_off;
        logic unused8;
        logic i2c_off;
        logic unused6;
        logic uart_off;
        logic unused4;
        logic spi_off;
        logic [1:0] unused2;
        logic adc_off;
    } pgc_gate_reg_type;

    // register select from address decode
    typedef enum logic [3:0] {
        SEL_GATE = 4'h1,
        SEL_STATUS = 4'h2,
        SEL_PRESENT = 4'h4,
        SEL_NONE = 4'h8
    } pgc_sel_type;

endpackage

// ===== verification/pgc_chk.sv
// pgc_chk.sv: port checks of the peripheral clock gate control block.
// assumes: bound to pgc_top; one clock, synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
`include "pgc_params.svh"

module pgc_chk #(
    parameter logic [15:0] PRESENT_MASK = `PGC_IMPL_MASK,
    parameter int GATE_DELAY = 1
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire pgc_pkg::pgc_axil_req_type axil_req_i,
    input wire pgc_pkg::pgc_axil_rsp_type axil_rsp_o,
    input wire logic [`PGC_NUM_PERIPH-1:0] periph_run_req_i,
    input wire logic [`PGC_NUM_PERIPH-1:0] periph_reg_wr_i,
    input wire logic [`PGC_NUM_PERIPH-1:0] periph_clk_en_o,
    input wire logic [`PGC_NUM_PERIPH-1:0] periph_reg_en_o,
    input wire logic [`PGC_NUM_PERIPH-1:0] periph_reg_wr_o
);
    localparam logic [15:0] PM = PRESENT_MASK & `PGC_IMPL_MASK;
    localparam logic [9:0] PRES = {PM[15], PM[14], PM[13], PM[12], PM[11], PM[9], PM[7], PM[5],
        PM[3], PM[0]};
    logic [15:0] wd_q, wd_d;
    logic [7:0] aw_q, aw_d, ar_q, ar_d;
    logic full_q, full_d;

    // ----------------------------------------
    // capture of the last bus requests
    // ----------------------------------------
    always_comb begin
        wd_d = wd_q;
        full_d = full_q;
        aw_d = axil_req_i.awvalid && axil_rsp_o.awready ? axil_req_i.awaddr : aw_q;
        ar_d = axil_req_i.arvalid && axil_rsp_o.arready ? axil_req_i.araddr : ar_q;
        if (axil_req_i.wvalid && axil_rsp_o.wready) begin
            wd_d = axil_req_i.wdata[15:0];
            full_d = &axil_req_i.wstrb[1:0];
        end
    end

    // registers the captured request fields
    always_ff @(posedge sys_clk_i) begin
        wd_q <= wd_d;
        full_q <= full_d;
        aw_q <= aw_d;
        ar_q <= ar_d;
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    chk_absent_stay_off: assert property ((periph_reg_en_o & ~PRES) == 10'h000)
        else $error("absent peripheral enabled");
    chk_wr_pass_gated: assert property (
        periph_reg_wr_o == ($past(periph_reg_wr_i) & $past(periph_reg_en_o)))
        else $error("register write strobe not gated by access enable");
    chk_clk_follow_run: assert property (
        periph_clk_en_o == ($past(periph_run_req_i) & periph_reg_en_o))
        else $error("clock enable not run request and gate");
    chk_reset_all_on: assert property ($fell(sys_rst_i) |=> periph_reg_en_o == PRES)
        else $error("present peripherals not enabled after reset");
    chk_gate_apply: assert property (
        $rose(axil_rsp_o.bvalid) && axil_rsp_o.bresp == `PGC_RESP_OKAY
        && aw_q == `PGC_GATE_OFFSET && full_q
        |=> periph_reg_en_o == (PRES & ~{wd_q[15:11], wd_q[9], wd_q[7], wd_q[5], wd_q[3],
        wd_q[0]}))
        else $error("gate write not applied one cycle later");
    chk_enable_hold: assert property (!$stable(periph_reg_en_o) |-> $past(sys_rst_i, 2)
        || ($past(axil_rsp_o.bvalid) && !$past(axil_rsp_o.bvalid, 2)))
        else $error("access enable changed without a gate write");
    chk_unimpl_read_zero: assert property (
        axil_rsp_o.rvalid && ar_q == `PGC_GATE_OFFSET |-> (axil_rsp_o.rdata & ~{16'h0000, PM}) == 0)
        else $error("unimplemented gate bits read nonzero");
    chk_write_answer: assert property (axil_req_i.awvalid && axil_rsp_o.awready
        && axil_req_i.wvalid && axil_rsp_o.wready |-> ##2 axil_rsp_o.bvalid)
        else $error("write response late");
    chk_read_answer: assert property (axil_req_i.arvalid && axil_rsp_o.arready
        |-> ##[1:2] axil_rsp_o.rvalid)
        else $error("read response late");

    cov_gate_write: cover property ($rose(axil_rsp_o.bvalid) && aw_q == `PGC_GATE_OFFSET);
    cov_decode_err: cover property (axil_rsp_o.rvalid && axil_rsp_o.rresp == `PGC_RESP_DECERR);
    cov_strobe_pass: cover property (|periph_reg_wr_o);
endmodule

bind pgc_top pgc_chk #(.PRESENT_MASK(PRESENT_MASK), .GATE_DELAY(GATE_DELAY)) u_chk (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .axil_req_i(axil_req_i),
    .axil_rsp_o(axil_rsp_o),
    .periph_run_req_i(periph_run_req_i),
    .periph_reg_wr_i(periph_reg_wr_i),
    .periph_clk_en_o(periph_clk_en_o),
    .periph_reg_en_o(periph_reg_en_o),
    .periph_reg_wr_o(periph_reg_wr_o)
);
`default_nettype wire

// ===== verification/testbench.sv
// testbench.sv: self-checking bench of the peripheral clock gate control block.
// assumes: pgc_pkg compiled first; pgc_params.svh on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "pgc_params.svh"

module testbench;
    localparam logic [15:0] MASK_B = 16'h3AA9; // variant without timers 4 and 5
    localparam logic [7:0] ADDR_NONE = 8'h0C;
    typedef struct packed {
        logic [31:0] d;
        logic [3:0] s;
        logic [15:0] e1;
        logic [15:0] e2;
    } pgc_row_type;
    pgc_row_type rows [0:7] = '{
        '{32'h0000FFFF, 4'hF, 16'hFAA9, 16'h3AA9}, '{32'h00000000, 4'hF, 16'h0000, 16'h0000},
        '{32'h00008001, 4'hF, 16'h8001, 16'h0001}, '{32'h00000208, 4'hF, 16'h0208, 16'h0208},
        '{32'hFFFFFFFF, 4'h1, 16'h02A9, 16'h02A9}, '{32'h0000FF00, 4'h2, 16'hFAA9, 16'h3AA9},
        '{32'h00000000, 4'hC, 16'hFAA9, 16'h3AA9}, '{32'h00004000, 4'hF, 16'h4000, 16'h0000}};
    logic sys_clk_i;
    logic sys_rst_i;
    pgc_pkg::pgc_axil_req_type req;
    pgc_pkg::pgc_axil_rsp_type rsp, rsp2;
    logic [9:0] run_req, reg_wr, clk_en, reg_en, reg_en2, reg_wr_o;
    logic [31:0] rd, rd2;
    logic [1:0] resp;
    int failures;
    int checks_done;

    pgc_top u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .axil_req_i(req),
        .axil_rsp_o(rsp), .periph_run_req_i(run_req), .periph_reg_wr_i(reg_wr),
        .periph_clk_en_o(clk_en), .periph_reg_en_o(reg_en), .periph_reg_wr_o(reg_wr_o));
    pgc_top #(.PRESENT_MASK(MASK_B)) u_dut2 (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .axil_req_i(req), .axil_rsp_o(rsp2), .periph_run_req_i(run_req),
        .periph_reg_wr_i(reg_wr), .periph_clk_en_o(), .periph_reg_en_o(reg_en2),
        .periph_reg_wr_o());

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [9:0] slots(input logic [15:0] v);
        return {v[15], v[14], v[13], v[12], v[11], v[9], v[7], v[5], v[3], v[0]};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // write cycle; called just after a rising edge, returns one edge after the answer
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        logic ta, tw, tb;
        int n;
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= s;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge sys_clk_i);
            ta = req.awvalid & rsp.awready;
            tw = req.wvalid & rsp.wready;
            tb = rsp.bvalid;
            r = rsp.bresp;
            @(posedge sys_clk_i);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
            if (tb) begin
                req.bready <= 1'b0;
                break;
            end
        end
        if (n == 40) check(32'h1, 32'h0, "write answer wait");
        @(posedge sys_clk_i);
    endtask

    // read cycle; data of both variants sampled at the same falling edge before the handshake edge
    task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [31:0] d2,
        output logic [1:0] r);
        logic ta, tr;
        int n;
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge sys_clk_i);
            ta = req.arvalid & rsp.arready;
            tr = rsp.rvalid;
            d = rsp.rdata;
            d2 = rsp2.rdata;
            r = rsp.rresp;
            @(posedge sys_clk_i);
            if (ta) req.arvalid <= 1'b0;
            if (tr) begin
                req.rready <= 1'b0;
                break;
            end
        end
        if (n == 40) check(32'h1, 32'h0, "read answer wait");
        @(posedge sys_clk_i);
    endtask

    // reset for four cycles, then check the power-up state
    task automatic reset_and_check;
        sys_rst_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge sys_clk_i);
        bus_read(`PGC_GATE_OFFSET, rd, rd2, resp);
        check(rd, 32'h0, "gate after reset");
        check(rd2, 32'h0, "gate after reset, small variant");
        check(reg_en, slots(`PGC_IMPL_MASK), "enables after reset");
        check(reg_en2, slots(MASK_B), "enables after reset, small variant");
        $display("reset test done");
    endtask

    // ----------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        #20000;
        check(32'h1, 32'h0, "watchdog expired");
        tally_and_finish;
    end

    initial begin
        req = '0;
        run_req = 10'h3FF;
        reg_wr = 10'h000;
        sys_rst_i = 1'b1;
        failures = 0;
        checks_done = 0;
        @(posedge sys_clk_i);
        reset_and_check;
        for (int i = 0; i < 8; i++) begin
            bus_write(`PGC_GATE_OFFSET, rows[i].d, rows[i].s, resp);
            check(resp, `PGC_RESP_OKAY, "gate write answer");
            bus_read(`PGC_GATE_OFFSET, rd, rd2, resp);
            check(rd, {16'h0000, rows[i].e1}, "gate readback");
            check(rd2, {16'h0000, rows[i].e2}, "gate readback, small variant");
            check(reg_en, slots(`PGC_IMPL_MASK & ~rows[i].e1), "access enables");
            check(reg_en2, slots(MASK_B & ~rows[i].e2), "small variant enables");
            bus_read(`PGC_STATUS_OFFSET, rd, rd2, resp);
            check(rd, {16'h0000, `PGC_IMPL_MASK & ~rows[i].e1}, "run status");
            $display("row %0d done", i);
        end
        // read-only and unmapped places
        bus_write(`PGC_STATUS_OFFSET, 32'h0000FFFF, 4'hF, resp);
        check(resp, `PGC_RESP_SLVERR, "status write answer");
        bus_write(ADDR_NONE, 32'h0000FFFF, 4'hF, resp);
        check(resp, `PGC_RESP_DECERR, "unmapped write answer");
        bus_read(ADDR_NONE, rd, rd2, resp);
        check({rd[29:0], resp}, 32'h3, "unmapped read data and answer");
        bus_read(`PGC_PRESENT_OFFSET, rd, rd2, resp);
        check(rd2, {16'h0000, MASK_B}, "present mask, small variant");
        bus_read(`PGC_GATE_OFFSET, rd, rd2, resp);
        check(rd, 32'h00004000, "gate kept after refused writes");
        $display("refusal test done");
        // run requests and gated register strobes
        bus_write(`PGC_GATE_OFFSET, 32'h00000008, 4'hF, resp);
        run_req <= 10'h155;
        reg_wr <= 10'h3FF;
        @(posedge sys_clk_i);
        reg_wr <= 10'h000;
        @(negedge sys_clk_i);
        check(clk_en, 10'h155 & slots(16'hFAA1), "clock enables with spi off");
        check(reg_wr_o, slots(16'hFAA1), "passed register writes");
        @(negedge sys_clk_i);
        check(reg_wr_o, 10'h000, "register write strobe length");
        @(posedge sys_clk_i);
        bus_write(`PGC_GATE_OFFSET, 32'h00000000, 4'hF, resp);
        check(clk_en, 10'h155, "no run request keeps clock off");
        check(reg_en, slots(`PGC_IMPL_MASK), "spi access back on");
        run_req <= 10'h3FF;
        $display("strobe test done");
        bus_write(`PGC_GATE_OFFSET, 32'h0000FFFF, 4'hF, resp);
        reset_and_check;
        tally_and_finish;
    end
endmodule
`default_nettype wire
